//--- hdl/fdl_pkg.sv
// fdl_pkg: constants, codes and carriers for the fault distance locator
package fdl_pkg;
    // apb register byte offsets
    localparam logic [11:0] FDL_CTRL_OFS = 12'h000;
    localparam logic [11:0] FDL_STATUS_OFS = 12'h004;
    localparam logic [11:0] FDL_COUNT_OFS = 12'h008;
    localparam logic [11:0] FDL_RSEL_OFS = 12'h00c;
    localparam logic [11:0] FDL_REC_OFS = 12'h010;
    localparam logic [11:0] FDL_THR_OFS = 12'h040;
    localparam logic [11:0] FDL_XKM_OFS = 12'h060;
    localparam int FDL_REC_WORDS = 6;
    // control field positions
    localparam int FDL_CTRL_SEL_LSB = 0;
    localparam int FDL_CTRL_MASK_LSB = 4;
    localparam int FDL_CTRL_CRST_BIT = 8;
    // reset values: 1.0 x nominal in tenths, 0.125 ohm/km in milliohm/km
    localparam logic [8:0] FDL_THR_RST = 9'h00a;
    localparam logic [12:0] FDL_XKM_RST = 13'h007d;
    localparam logic [3:0] FDL_MASK_RST = 4'hf;
    // threshold tenths to milli-nominal scale
    localparam logic [15:0] FDL_THR_SCALE = 16'h0064;
    // distance is kept in hundredths of a kilometre
    localparam logic [23:0] FDL_DIST_SCALE = 24'h000064;
    localparam int FDL_DIV_STEPS = 24;
    localparam int FDL_NREC = 12;
    // fault type codes
    localparam logic [2:0] FDL_FT_NONE = 3'h0;
    localparam logic [2:0] FDL_FT_L12 = 3'h1;
    localparam logic [2:0] FDL_FT_L23 = 3'h2;
    localparam logic [2:0] FDL_FT_L31 = 3'h3;
    localparam logic [2:0] FDL_FT_L1N = 3'h4;
    localparam logic [2:0] FDL_FT_L2N = 3'h5;
    localparam logic [2:0] FDL_FT_L3N = 3'h6;
    localparam logic [2:0] FDL_FT_L123 = 3'h7;
    // event codes, also the bit order of the event mask
    localparam logic [1:0] FDL_EV_TRIG_ON = 2'h0;
    localparam logic [1:0] FDL_EV_TRIG_OFF = 2'h1;
    localparam logic [1:0] FDL_EV_CALC_ON = 2'h2;
    localparam logic [1:0] FDL_EV_CALC_OFF = 2'h3;

    typedef enum logic [1:0] {FDL_IDLE, FDL_DIV, FDL_STORE} fdl_state_e;

    // one stored fault record
    typedef struct packed {
        logic [47:0] time_ms;
        logic [1:0] evt;
        logic [2:0] ftype;
        logic [1:0] dir;
        logic [15:0] react_mohm;
        logic [15:0] cur_mpu;
        logic [31:0] cur_prim_ma;
        logic [15:0] dist_ckm;
        logic [2:0] grp;
    } fdl_rec_s;

    // one event towards the event buffer
    typedef struct packed {
        logic valid;
        logic [1:0] code;
        logic [47:0] time_ms;
    } fdl_evt_s;
endpackage : fdl_pkg

//--- hdl/fdl_fault_locator.sv
// fdl_fault_locator: trigger, loop choice, distance, events and records
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module fdl_fault_locator
    import fdl_pkg::*;
#(
    parameter int TRIG_W = 16,
    parameter int NGRP = 8
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // process side, same clock
    input wire logic cycle_tick,
    input wire logic [TRIG_W-1:0] trig_sources,
    input wire logic calc_block,
    input wire logic pe_volt_avail,
    input wire logic [15:0] phase_one_current_fundamental,
    input wire logic [15:0] phase_two_current_fundamental,
    input wire logic [15:0] phase_three_current_fundamental,
    input wire logic [15:0] loop_reactance_pair_one_two,
    input wire logic [15:0] loop_reactance_pair_two_three,
    input wire logic [15:0] loop_reactance_pair_three_one,
    input wire logic [15:0] loop_reactance_phase_one_neutral,
    input wire logic [15:0] loop_reactance_phase_two_neutral,
    input wire logic [15:0] loop_reactance_phase_three_neutral,
    input wire logic [15:0] ct_primary_amps,
    input wire logic [1:0] fault_dir,
    input wire logic [2:0] grp_sel,
    input wire logic [47:0] now_ms,
    output fdl_evt_s evt_out,
    output logic blocked_ind,
    output logic calc_busy
);
    ////////////////////////////////////////////////////////////////////////
    // helpers

    // current above threshold given in tenths of nominal
    function automatic logic over_thr(input logic [15:0] cur,
                                      input logic [8:0] thr);
        logic [15:0] lim;
        lim = {7'h00, thr} * FDL_THR_SCALE;
        return cur > lim;
    endfunction : over_thr

    // loop choice from phases over threshold and earth voltage presence
    function automatic logic [2:0] pick_loop(input logic [2:0] ov,
                                             input logic volt);
        logic [2:0] ft;
        ft = FDL_FT_NONE;
        unique case (ov)
            3'h7: ft = FDL_FT_L123;
            3'h3: ft = FDL_FT_L12;
            3'h6: ft = FDL_FT_L23;
            3'h5: ft = FDL_FT_L31;
            3'h1: ft = volt ? FDL_FT_L1N : FDL_FT_NONE;
            3'h2: ft = volt ? FDL_FT_L2N : FDL_FT_NONE;
            3'h4: ft = volt ? FDL_FT_L3N : FDL_FT_NONE;
            3'h0: ft = FDL_FT_NONE;
        endcase
        return ft;
    endfunction : pick_loop

    ////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [3:0] trig_sel_ff;
    logic [3:0] evt_mask_ff;
    logic [3:0] rec_sel_ff;
    logic [8:0] thr_ff [NGRP];
    logic [12:0] xkm_ff [NGRP];
    logic [31:0] count_ff;
    logic trig_lvl_ff;
    logic blocked_ff;
    fdl_state_e state_ff;
    logic [3:0] pend_ff;
    fdl_evt_s evt_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    fdl_rec_s rec_mem [FDL_NREC];
    logic [3:0] wptr_ff;
    logic [3:0] nrec_ff;
    fdl_rec_s cap_ff;
    logic [12:0] den_ff;
    logic [23:0] num_ff;
    logic [12:0] rem_ff;
    logic [4:0] step_ff;

    logic wr_en;
    logic rd_setup;
    logic trig_now;
    logic trig_rise;
    logic trig_fall;
    logic cnt_clear;
    logic [2:0] ovr;
    logic [2:0] loop_ft;
    logic [15:0] loop_x;
    logic [15:0] loop_i;
    logic [2:0] grp_idx;
    logic [13:0] nxt_rem;
    logic [31:0] rd_val;
    logic rd_err;

    ////////////////////////////////////////////////////////////////////////
    // apb access decode; reads are captured in the setup cycle

    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_setup = psel && !penable && clk_en;
    assign pready = psel && penable && clk_en;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff && pready;
    assign cnt_clear = wr_en && paddr == FDL_CTRL_OFS
                       && pwdata[FDL_CTRL_CRST_BIT];

    // group index clamps out-of-range selections to the last group
    assign grp_idx = (32'(grp_sel) < NGRP) ? grp_sel : 3'(NGRP - 1);

    ////////////////////////////////////////////////////////////////////////
    // trigger, block, and loop choice at the program cycle tick

    assign trig_now = trig_sources[trig_sel_ff];
    assign trig_rise = cycle_tick && trig_now && !trig_lvl_ff;
    assign trig_fall = cycle_tick && !trig_now && trig_lvl_ff;

    // only fundamental components feed the comparison and loop values
    assign ovr = {over_thr(phase_three_current_fundamental,
                           thr_ff[grp_idx]),
                  over_thr(phase_two_current_fundamental, thr_ff[grp_idx]),
                  over_thr(phase_one_current_fundamental,
                           thr_ff[grp_idx])};
    assign loop_ft = pick_loop(ovr, pe_volt_avail);

    // reactance and current of the chosen loop
    always_comb
    begin
        loop_x = loop_reactance_pair_one_two;
        loop_i = phase_one_current_fundamental;
        unique case (loop_ft)
            FDL_FT_L12, FDL_FT_L123:
            begin
                loop_x = loop_reactance_pair_one_two;
                loop_i = phase_one_current_fundamental;
            end
            FDL_FT_L23:
            begin
                loop_x = loop_reactance_pair_two_three;
                loop_i = phase_two_current_fundamental;
            end
            FDL_FT_L31:
            begin
                loop_x = loop_reactance_pair_three_one;
                loop_i = phase_three_current_fundamental;
            end
            FDL_FT_L1N, FDL_FT_NONE:
            begin
                loop_x = loop_reactance_phase_one_neutral;
                loop_i = phase_one_current_fundamental;
            end
            FDL_FT_L2N:
            begin
                loop_x = loop_reactance_phase_two_neutral;
                loop_i = phase_two_current_fundamental;
            end
            FDL_FT_L3N:
            begin
                loop_x = loop_reactance_phase_three_neutral;
                loop_i = phase_three_current_fundamental;
            end
        endcase
    end

    // trigger level and block flag follow the tick only
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trig_lvl_ff <= 1'b0;
            blocked_ff <= 1'b0;
        end
        else if (clk_en && cycle_tick)
        begin
            trig_lvl_ff <= trig_now;
            if (trig_rise)
                blocked_ff <= calc_block;
            else if (!trig_now)
                blocked_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calculation sequence: capture, divide, store

    // one restoring step; remainder stays below the divisor
    assign nxt_rem = {rem_ff, num_ff[23]};

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= FDL_IDLE;
            cap_ff <= '0;
            den_ff <= 13'h0000;
            num_ff <= 24'h000000;
            rem_ff <= 13'h0000;
            step_ff <= 5'h00;
        end
        else if (clk_en)
        begin
            unique case (state_ff)
                FDL_IDLE:
                    // a trigger that is blocked goes no further
                    if (trig_rise && !calc_block && loop_ft != FDL_FT_NONE)
                    begin
                        cap_ff.time_ms <= now_ms;
                        cap_ff.evt <= FDL_EV_CALC_ON;
                        cap_ff.ftype <= loop_ft;
                        cap_ff.dir <= fault_dir;
                        cap_ff.react_mohm <= loop_x;
                        cap_ff.cur_mpu <= loop_i;
                        cap_ff.cur_prim_ma <= loop_i * ct_primary_amps;
                        cap_ff.dist_ckm <= 16'h0000;
                        cap_ff.grp <= grp_idx;
                        den_ff <= xkm_ff[grp_idx];
                        num_ff <= {8'h00, loop_x} * FDL_DIST_SCALE;
                        rem_ff <= 13'h0000;
                        step_ff <= 5'h00;
                        // zero setting: no division, distance left at zero
                        state_ff <= (xkm_ff[grp_idx] == 13'h0000)
                                    ? FDL_STORE : FDL_DIV;
                    end
                FDL_DIV:
                begin
                    num_ff <= {num_ff[22:0], 1'b0};
                    if (nxt_rem >= {1'b0, den_ff})
                    begin
                        rem_ff <= 13'(nxt_rem - {1'b0, den_ff});
                        num_ff[0] <= 1'b1;
                    end
                    else
                        rem_ff <= nxt_rem[12:0];
                    step_ff <= step_ff + 5'h01;
                    if (32'(step_ff) == FDL_DIV_STEPS - 1)
                        state_ff <= FDL_STORE;
                end
                FDL_STORE:
                    state_ff <= FDL_IDLE;
            endcase
            // quotient ends up in num_ff; saturate into the record
            if (state_ff == FDL_DIV && 32'(step_ff) == FDL_DIV_STEPS - 1)
                cap_ff.dist_ckm <= (num_ff[22:15] != 8'h00) ? 16'hffff
                                   : {num_ff[14:0],
                                      nxt_rem >= {1'b0, den_ff}};
        end
    end

    // rolling record store; oldest entry is overwritten
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wptr_ff <= 4'h0;
            nrec_ff <= 4'h0;
        end
        else if (clk_en && state_ff == FDL_STORE)
        begin
            wptr_ff <= (32'(wptr_ff) == FDL_NREC - 1) ? 4'h0
                       : wptr_ff + 4'h1;
            if (32'(nrec_ff) < FDL_NREC)
                nrec_ff <= nrec_ff + 4'h1;
        end
    end

    // record memory holds no reset; validity comes from the fill count
    always_ff @(posedge clock)
    begin
        if (clk_en && state_ff == FDL_STORE)
            rec_mem[wptr_ff] <= cap_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // events: pending flags so that close events are never lost

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_ff <= 4'h0;
            evt_ff <= '0;
        end
        else if (clk_en)
        begin
            logic [3:0] p;
            p = pend_ff;
            evt_ff.valid <= 1'b0;
            // emit the lowest pending code, then set new ones (set wins)
            for (int k = 0; k < 4; k++)
            begin
                if (p[k])
                begin
                    evt_ff.valid <= evt_mask_ff[k];
                    evt_ff.code <= 2'(k);
                    evt_ff.time_ms <= now_ms;
                    p[k] = 1'b0;
                    break;
                end
            end
            if (trig_rise)
                p[FDL_EV_TRIG_ON] = 1'b1;
            if (trig_fall)
                p[FDL_EV_TRIG_OFF] = 1'b1;
            if (state_ff == FDL_IDLE && trig_rise && !calc_block
                && loop_ft != FDL_FT_NONE)
                p[FDL_EV_CALC_ON] = 1'b1;
            if (state_ff == FDL_STORE)
                p[FDL_EV_CALC_OFF] = 1'b1;
            pend_ff <= p;
        end
    end

    assign evt_out = evt_ff;
    assign blocked_ind = blocked_ff;
    assign calc_busy = state_ff != FDL_IDLE;

    // trigger counter; a trigger in the clear cycle still counts
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            count_ff <= 32'h00000000;
        else if (clk_en)
        begin
            if (cnt_clear)
                count_ff <= {31'h00000000, trig_rise};
            else if (trig_rise)
                count_ff <= count_ff + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software settings; group tables let settings change live

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trig_sel_ff <= 4'h0;
            evt_mask_ff <= FDL_MASK_RST;
            rec_sel_ff <= 4'h0;
            for (int g = 0; g < NGRP; g++)
            begin
                thr_ff[g] <= FDL_THR_RST;
                xkm_ff[g] <= FDL_XKM_RST;
            end
        end
        else if (wr_en)
        begin
            if (paddr == FDL_CTRL_OFS)
            begin
                trig_sel_ff <= pwdata[FDL_CTRL_SEL_LSB +: 4];
                evt_mask_ff <= pwdata[FDL_CTRL_MASK_LSB +: 4];
            end
            if (paddr == FDL_RSEL_OFS)
                rec_sel_ff <= pwdata[3:0];
            for (int g = 0; g < NGRP; g++)
            begin
                if (paddr == FDL_THR_OFS + 12'(4 * g))
                    thr_ff[g] <= pwdata[8:0];
                if (paddr == FDL_XKM_OFS + 12'(4 * g))
                    xkm_ff[g] <= pwdata[12:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; record age 0 is the newest entry

    always_comb
    begin
        logic [4:0] ix;
        fdl_rec_s r;
        ix = {1'b0, wptr_ff} + 5'h0b - {1'b0, rec_sel_ff};
        if (ix >= 5'h0c)
            ix = ix - 5'h0c;
        r = (rec_sel_ff < nrec_ff) ? rec_mem[ix[3:0]] : '0;
        rd_val = 32'h00000000;
        rd_err = 1'b0;
        if (paddr == FDL_CTRL_OFS)
            rd_val = {24'h000000, evt_mask_ff, trig_sel_ff};
        else if (paddr == FDL_STATUS_OFS)
            rd_val = {25'h0000000, nrec_ff, calc_busy, blocked_ff,
                      trig_lvl_ff};
        else if (paddr == FDL_COUNT_OFS)
            rd_val = count_ff;
        else if (paddr == FDL_RSEL_OFS)
            rd_val = {28'h0000000, rec_sel_ff};
        else if (paddr == FDL_REC_OFS)
            rd_val = r.time_ms[31:0];
        else if (paddr == FDL_REC_OFS + 12'h004)
            rd_val = {16'h0000, r.time_ms[47:32]};
        else if (paddr == FDL_REC_OFS + 12'h008)
            rd_val = {22'h000000, r.grp, r.dir, r.ftype, r.evt};
        else if (paddr == FDL_REC_OFS + 12'h00c)
            rd_val = {r.cur_mpu, r.react_mohm};
        else if (paddr == FDL_REC_OFS + 12'h010)
            rd_val = r.cur_prim_ma;
        else if (paddr == FDL_REC_OFS + 12'(4 * (FDL_REC_WORDS - 1)))
            rd_val = {16'h0000, r.dist_ckm};
        else if (paddr >= FDL_THR_OFS
                 && paddr < FDL_THR_OFS + 12'(4 * NGRP)
                 && paddr[1:0] == 2'h0)
            rd_val = {23'h000000, thr_ff[3'(paddr[4:2])]};
        else if (paddr >= FDL_XKM_OFS
                 && paddr < FDL_XKM_OFS + 12'(4 * NGRP)
                 && paddr[1:0] == 2'h0)
            rd_val = {19'h00000, xkm_ff[3'(paddr[4:2])]};
        else
            rd_err = 1'b1;
    end

    // read data and error latched at setup, stable through the access
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else if (rd_setup)
        begin
            prdata_ff <= pwrite ? 32'h00000000 : rd_val;
            pslverr_ff <= rd_err;
        end
    end
endmodule : fdl_fault_locator

//--- sim/fdl_fault_locator_checker.sv
// fdl_checker: port assertions for the fault distance locator
`timescale 1ns/1ps
module fdl_checker
    import fdl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cycle_tick,
    input wire logic calc_block,
    input wire fdl_evt_s evt_out,
    input wire logic blocked_ind,
    input wire logic calc_busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // masked events keep their slot, so only a valid code is judged
    sequence s_evts;
        (!evt_out.valid || evt_out.code == FDL_EV_TRIG_ON) ##1
        (!evt_out.valid || evt_out.code == FDL_EV_CALC_ON);
    endsequence
    // rest of a divide run from its second busy cycle, then the store;
    // a zero setting skips the divide and is busy for one cycle only
    sequence s_run;
        calc_busy ##23 calc_busy ##1 !calc_busy;
    endsequence
    a_apb_ready:
        assert property (pready == (psel && penable && clk_en))
        else $error("pready not zero wait");
    a_err_ready:
        assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    a_busy_tick:
        assert property ($rose(calc_busy) |-> $past(cycle_tick))
        else $error("run started off tick");
    a_blk_rise:
        assert property ($rose(blocked_ind) |-> $past(cycle_tick)
            && $past(calc_block) && !$rose(calc_busy))
        else $error("blocked flag without block");
    a_blk_fall:
        assert property ($fell(blocked_ind) |-> $past(cycle_tick))
        else $error("blocked flag cleared off tick");
    a_calc_run:
        assert property ($rose(calc_busy) ##1 calc_busy |-> s_run)
        else $error("run length wrong");
    a_calc_evts:
        assert property ($rose(calc_busy) |-> ##1 s_evts)
        else $error("start events out of order");
    a_calc_off:
        assert property ($fell(calc_busy) |-> ##[0:2]
            (evt_out.valid && evt_out.code == FDL_EV_CALC_OFF))
        else $error("calc off event missing");
endmodule : fdl_checker

bind fdl_fault_locator fdl_checker u_fdl_checker (.*);

//--- sim/fdl_src_model.sv
// fdl_src_model: program cycle strobe and trip and block sources
`timescale 1ns/1ps
module fdl_src_model
    import fdl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic trip_lvl,
    input wire logic blk_lvl,
    output logic cycle_tick,
    output logic [15:0] trig_sources,
    output logic calc_block
);
    logic [2:0] div_ff;
    ////////////////////////////////////////////////////////////////////////
    // tick every 8 clocks; trip on source five so the selector matters
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_ff <= 3'h0;
            cycle_tick <= 1'b0;
            trig_sources <= 16'h0000;
            calc_block <= 1'b0;
        end
        else
        begin
            div_ff <= div_ff + 3'h1;
            cycle_tick <= (div_ff == 3'h7);
            trig_sources <= {10'h000, trip_lvl, 5'h00};
            calc_block <= blk_lvl;
        end
    end
endmodule : fdl_src_model

//--- sim/test_fdl_fault_locator.sv
// test_fdl_fault_locator: self-checking bench for the fault locator
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_fdl_fault_locator
    import fdl_pkg::*;
;
    logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, cycle_tick, calc_block, blocked_ind, calc_busy;
    logic trip_lvl = 1'b0, blk_lvl = 1'b0, pe_volt_avail = 1'b0;
    logic [15:0] trig_sources, ct_primary_amps = 16'h0064;
    logic [15:0] i [3] = '{16'h0, 16'h0, 16'h0};
    logic [15:0] xr [6] = '{16'h00fa, 16'h01f4, 16'h02ee, 16'h03e8,
        16'h04e2, 16'h05dc};
    logic [1:0] fault_dir = 2'h1;
    logic [2:0] grp_sel = 3'h0;
    logic [47:0] now_ms = 48'h0;
    fdl_evt_s evt_out;
    int n_errors = 0, check_count = 0, n_trig = 0, n_rec = 0;
    ////////////////////////////////////////////////////////////////////////
    fdl_src_model u_fdl_src_model (.*);
    fdl_fault_locator u_fdl_fault_locator (.*,
        .phase_one_current_fundamental(i[0]),
        .phase_two_current_fundamental(i[1]),
        .phase_three_current_fundamental(i[2]),
        .loop_reactance_pair_one_two(xr[0]),
        .loop_reactance_pair_two_three(xr[1]),
        .loop_reactance_pair_three_one(xr[2]),
        .loop_reactance_phase_one_neutral(xr[3]),
        .loop_reactance_phase_two_neutral(xr[4]),
        .loop_reactance_phase_three_neutral(xr[5]));
    // 10 MHz clock
    initial
    begin
        forever #50 clock = ~clock;
    end
    // far beyond the expected run, so only a hang gets here
    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    // apb read or write; waits for pready, result left in r and e
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // trip high until the run ends, then low long enough to re-arm
    task automatic fire();
        int k;
        trip_lvl <= 1'b1;
        repeat (12) @(posedge clock);
        for (k = 0; k < 40 && calc_busy === 1'b1; k++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        trip_lvl <= 1'b0;
        repeat (20) @(posedge clock);
        n_trig++;
    endtask : fire
    // currents in tenths of nominal; loop reactance is 250 mohm per code
    task automatic t_fault(input logic [7:0] a1, a2, a3, input logic v,
        input logic [2:0] g, ft);
        logic [15:0] cur;
        logic [2:0] lp;
        logic [31:0] dx;
        cur = 16'(ft % 3 == 1 ? a1 : ft % 3 == 2 ? a2 : a3) * 16'h0064;
        // three-phase faults record the 1-2 loop
        lp = (ft == FDL_FT_L123) ? FDL_FT_L12 : ft;
        // group 3 has a zero reactance setting, so no distance
        dx = (g == 3'h3) ? 32'h0 : 32'(lp) * 32'h61a8 / 32'h7d;
        i <= '{16'(a1) * 16'h0064, 16'(a2) * 16'h0064, 16'(a3) * 16'h0064};
        pe_volt_avail <= v;
        grp_sel <= g;
        fire();
        if (ft != FDL_FT_NONE && n_rec < FDL_NREC)
            n_rec++;
        apb(1'b0, FDL_STATUS_OFS, 32'h0);
        `CHK("stored", 4'(n_rec), r[6:3])
        apb(1'b0, FDL_COUNT_OFS, 32'h0);
        `CHK("count", 32'(n_trig), r)
        if (ft != FDL_FT_NONE)
        begin
            apb(1'b0, FDL_REC_OFS + 12'h008, 32'h0);
            `CHK("kind", {22'h0, g, fault_dir, ft, FDL_EV_CALC_ON}, r)
            apb(1'b0, FDL_REC_OFS + 12'h00c, 32'h0);
            `CHK("react", {cur, 16'(lp) * 16'h00fa}, r)
            apb(1'b0, FDL_REC_OFS + 12'h010, 32'h0);
            `CHK("primary", 32'(cur) * 32'h64, r)
            apb(1'b0, FDL_REC_OFS + 12'h014, 32'h0);
            `CHK("dist", dx, r)
        end
    endtask : t_fault
    // reset values, an unmapped place, source select, group 1 threshold
    task automatic t_regs();
        apb(1'b0, FDL_THR_OFS, 32'h0);
        `CHK("thr", 32'h0000000a, r)
        apb(1'b0, FDL_XKM_OFS + 12'h004, 32'h0);
        `CHK("xkm", 32'h0000007d, r)
        apb(1'b0, 12'h7f0, 32'h0);
        `CHK("unmapped", 1'b1, e)
        apb(1'b1, FDL_CTRL_OFS, 32'h000000f5);
        apb(1'b1, FDL_THR_OFS + 12'h004, 32'h0000001e);
        apb(1'b1, FDL_XKM_OFS + 12'h00c, 32'h0);
    endtask : t_regs
    // block leads the trip by a tick: flag only, no run, no record
    task automatic t_block();
        blk_lvl <= 1'b1;
        repeat (8) @(posedge clock);
        trip_lvl <= 1'b1;
        repeat (12) @(posedge clock);
        `CHK("blocked", 1'b1, blocked_ind)
        `CHK("no run", 1'b0, calc_busy)
        trip_lvl <= 1'b0;
        repeat (12) @(posedge clock);
        `CHK("unblocked", 1'b0, blocked_ind)
        blk_lvl <= 1'b0;
        n_trig++;
    endtask : t_block
    // overfill the store: age 11 is the second record, age 12 is empty
    task automatic t_roll();
        int k;
        for (k = 0; k < 6; k++)
            t_fault(8'h0f, 8'h0f, 8'h0f, 1'b1, 3'h0, FDL_FT_L123);
        apb(1'b1, FDL_RSEL_OFS, 32'h0000000b);
        apb(1'b0, FDL_REC_OFS + 12'h008, 32'h0);
        `CHK("oldest", {27'h0, FDL_FT_L23, 2'h2} | 32'h20, r)
        apb(1'b1, FDL_RSEL_OFS, 32'h0000000c);
        apb(1'b0, FDL_REC_OFS + 12'h008, 32'h0);
        `CHK("past end", 32'h0, r)
        apb(1'b1, FDL_RSEL_OFS, 32'h0);
    endtask : t_roll
    // counter clear, then counting restarts from the next trigger
    task automatic t_clear();
        apb(1'b1, FDL_CTRL_OFS, 32'h000001f5);
        apb(1'b0, FDL_COUNT_OFS, 32'h0);
        `CHK("cleared", 32'h0, r)
        n_trig = 0;
        t_fault(8'h0f, 8'h0f, 8'h0f, 1'b1, 3'h0, FDL_FT_L123);
    endtask : t_clear
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_fault(8'h0f, 8'h0f, 8'h00, 1'b1, 3'h0, FDL_FT_L12);
        t_block();
        t_fault(8'h00, 8'h0f, 8'h0f, 1'b0, 3'h0, FDL_FT_L23);
        t_fault(8'h0f, 8'h00, 8'h0c, 1'b0, 3'h0, FDL_FT_L31);
        t_fault(8'h0a, 8'h14, 8'h00, 1'b1, 3'h0, FDL_FT_L2N);
        t_fault(8'h00, 8'h00, 8'h12, 1'b1, 3'h0, FDL_FT_L3N);
        t_fault(8'h12, 8'h00, 8'h00, 1'b1, 3'h0, FDL_FT_L1N);
        t_fault(8'h12, 8'h00, 8'h00, 1'b0, 3'h0, FDL_FT_NONE);
        t_fault(8'h05, 8'h00, 8'h00, 1'b1, 3'h0, FDL_FT_NONE);
        t_fault(8'h14, 8'h14, 8'h14, 1'b1, 3'h1, FDL_FT_NONE);
        t_fault(8'h14, 8'h14, 8'h14, 1'b1, 3'h2, FDL_FT_L123);
        t_roll();
        t_fault(8'h00, 8'h0f, 8'h0f, 1'b0, 3'h3, FDL_FT_L23);
        t_clear();
        test_done();
    end
endmodule : test_fdl_fault_locator
